/* logic/crcx_top.v */
// configurable crc engine with an axi4-lite register slave and scanner input
// assumes a single 20 MHz clock aclk and synchronous active-low reset aresetn;
// the scanner port is driven by logic on the same clock
//
// Summary of operation
// - words come from registers or scanner
// - polynomial up to 17 bits, length n-2
// - interior coefficients stored in bits 15:1
// - lowest coefficient always one, reads zero
// - xor feedback shift register divides
// - software seeds the accumulator before starting
// - result readable from the accumulator register
// - only word-length low bits used
// - order clear: msb first from word length
// - order set: lsb first, reversed order
// - low byte write loads the intermediate shifter
// - bits shift from intermediate shifter only
// - augment appends zero bits, poly length plus one
// - done flag set on busy falling edge
`timescale 1ns/10ps
`default_nettype none
`include "crcx_regs.vh"

module crcx_top #(
   parameter W = 16
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [`CRCX_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [`CRCX_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // program-memory scanner words
   input wire [W-1:0] scan_data,
   input wire scan_valid,
   output wire scan_ready,
   // interrupt
   output wire irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg go_q, augment_q, order_q;
   reg [3:0] word_len_q, poly_len_q;
   reg [W-1:0] acc_q;
   reg [W-1:1] poly_q;
   reg [7:0] word_low_q, word_high_q;
   reg [W-1:0] shifter_q;
   reg [3:0] bit_cnt_q;
   reg data_act_q;
   reg aug_act_q, aug_pend_q;
   reg [3:0] aug_cnt_q;
   reg busy_prev_q;
   reg done_flag_q, done_mask_q;
   reg [`CRCX_ADDR_W-1:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg aw_full_q, w_full_q;

   wire busy;
   wire [W-1:0] step_out;
   wire wr_fire;
   reg [3:0] bit_idx;
   reg step_din;
   reg step_en;

   // ------------------------------------------------------------
   // byte-lane merge, used by the check_control_1, accumulator and polynomial writes
   // ------------------------------------------------------------
   function [31:0] lane_merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] strb;
      integer k;
      begin
         lane_merge = old_val;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               lane_merge[8*k +: 8] = new_val[8*k +: 8];
            end
         end
      end
   endfunction

   function is_mapped;
      input [`CRCX_ADDR_W-1:0] a;
      begin
         is_mapped = (a[1:0] == 2'b00) && (a <= `CRCX_OFS_IRQ_MASK);
      end
   endfunction

   // ------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready = !w_full_q;
   assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= {`CRCX_ADDR_W{1'b0}};
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CRCX_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(awaddr_q) ? `CRCX_RESP_OKAY : `CRCX_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CRCX_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= is_mapped(s_axi_araddr) ? `CRCX_RESP_OKAY : `CRCX_RESP_SLVERR;
         case (s_axi_araddr)
            `CRCX_OFS_CHECK_CONTROL_0:
               s_axi_rdata <= {26'h000_0000, data_act_q, busy, 1'b0, order_q, augment_q, go_q};
            `CRCX_OFS_CHECK_CONTROL_1:
               s_axi_rdata <= {24'h00_0000, poly_len_q, word_len_q};
            `CRCX_OFS_CHECK_ACCUMULATOR:
               s_axi_rdata <= {16'h0000, acc_q};
            `CRCX_OFS_GENERATOR_POLY_REG:
               s_axi_rdata <= {16'h0000, poly_q, 1'b0};
            `CRCX_OFS_INPUT_WORD_LOW:
               s_axi_rdata <= {24'h00_0000, word_low_q};
            `CRCX_OFS_INPUT_WORD_HIGH:
               s_axi_rdata <= {24'h00_0000, word_high_q};
            `CRCX_OFS_IRQ_STATUS:
               s_axi_rdata <= {31'h0000_0000, done_flag_q};
            `CRCX_OFS_IRQ_MASK:
               s_axi_rdata <= {31'h0000_0000, done_mask_q};
            default:
               s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // word intake from software or scanner
   // ------------------------------------------------------------
   wire wr_ctrl0 = wr_fire && (awaddr_q == `CRCX_OFS_CHECK_CONTROL_0) && wstrb_q[0];
   wire wr_low = wr_fire && (awaddr_q == `CRCX_OFS_INPUT_WORD_LOW) && wstrb_q[0];
   wire [31:0] wr_merged_ctrl = lane_merge({24'h00_0000, poly_len_q, word_len_q}, wdata_q, wstrb_q);
   wire [31:0] wr_merged_acc = lane_merge({16'h0000, acc_q}, wdata_q, wstrb_q);
   wire [31:0] wr_merged_poly = lane_merge({16'h0000, poly_q, 1'b0}, wdata_q, wstrb_q);
   // a word is taken only while the shifter is empty; a low write while full is dropped
   wire sw_load = wr_low && !data_act_q && !aug_act_q;
   assign scan_ready = go_q && !data_act_q && !aug_act_q && !sw_load;
   wire scan_load = scan_valid && scan_ready;
   wire go_falls = wr_ctrl0 && !wdata_q[`CRCX_C0_CALC_GO] && go_q;

   assign busy = data_act_q || aug_act_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         {order_q, augment_q, go_q} <= `CRCX_RST_CTRL0;
         {poly_len_q, word_len_q} <= `CRCX_RST_CTRL1;
         poly_q <= {(W-1){1'b0}};
         word_low_q <= 8'h00;
         word_high_q <= 8'h00;
         done_mask_q <= 1'b0;
      end else begin
         if (wr_ctrl0) begin
            go_q <= wdata_q[`CRCX_C0_CALC_GO];
            augment_q <= wdata_q[`CRCX_C0_AUGMENT];
            order_q <= wdata_q[`CRCX_C0_BIT_ORDER];
         end
         if (wr_fire && awaddr_q == `CRCX_OFS_CHECK_CONTROL_1) begin
            word_len_q <= wr_merged_ctrl[`CRCX_C1_WORD_LEN_LSB +: `CRCX_LEN_W];
            poly_len_q <= wr_merged_ctrl[`CRCX_C1_POLY_LEN_LSB +: `CRCX_LEN_W];
         end
         if (wr_fire && awaddr_q == `CRCX_OFS_GENERATOR_POLY_REG) begin
            poly_q <= wr_merged_poly[W-1:1];
         end
         if (wr_fire && awaddr_q == `CRCX_OFS_INPUT_WORD_HIGH && wstrb_q[0]) begin
            word_high_q <= wdata_q[7:0];
         end
         if (wr_low) begin
            word_low_q <= wdata_q[7:0];
         end else if (scan_load) begin
            {word_high_q, word_low_q} <= scan_data;
         end
         if (wr_fire && awaddr_q == `CRCX_OFS_IRQ_MASK && wstrb_q[0]) begin
            done_mask_q <= wdata_q[`CRCX_IRQ_DONE];
         end
      end
   end

   // ------------------------------------------------------------
   // shift sequencer
   // ------------------------------------------------------------
   always @* begin
      bit_idx = order_q ? (word_len_q - bit_cnt_q) : bit_cnt_q;
      step_din = 1'b0;
      step_en = 1'b0;
      // a word still in flight when go drops finishes ahead of the zeros
      if (data_act_q && (go_q || aug_act_q)) begin
         step_din = shifter_q[bit_idx];
         step_en = 1'b1;
      end else if (aug_act_q) begin
         step_en = 1'b1;
      end
   end

   crcx_step #(
      .W(W)
   ) u_step (
      .acc_in(acc_q),
      .din(step_din),
      .poly_hi(poly_q),
      .top_idx(poly_len_q),
      .acc_out(step_out)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         acc_q <= `CRCX_RST_WORD;
         shifter_q <= `CRCX_RST_WORD;
         bit_cnt_q <= 4'h0;
         data_act_q <= 1'b0;
         aug_act_q <= 1'b0;
         aug_pend_q <= 1'b0;
         aug_cnt_q <= 4'h0;
      end else begin
         if (sw_load || scan_load) begin
            // bits above the word length never reach the divider
            shifter_q <= sw_load ? {word_high_q, wdata_q[7:0]} : scan_data;
            bit_cnt_q <= word_len_q;
            data_act_q <= 1'b1;
         end else if (step_en && data_act_q) begin
            bit_cnt_q <= bit_cnt_q - 4'h1;
            if (bit_cnt_q == 4'h0) begin
               data_act_q <= 1'b0;
               aug_pend_q <= 1'b1;
            end
         end
         // zeros follow the last word once software drops go
         if (go_falls && augment_q && (aug_pend_q || data_act_q)) begin
            aug_act_q <= 1'b1;
            aug_cnt_q <= poly_len_q;
            aug_pend_q <= 1'b0;
         end else if (aug_act_q && !data_act_q) begin
            aug_cnt_q <= aug_cnt_q - 4'h1;
            if (aug_cnt_q == 4'h0) begin
               aug_act_q <= 1'b0;
            end
         end else if (go_falls) begin
            aug_pend_q <= 1'b0;
         end
         if (step_en) begin
            acc_q <= step_out;
         end else if (wr_fire && awaddr_q == `CRCX_OFS_CHECK_ACCUMULATOR && !busy) begin
            acc_q <= wr_merged_acc[W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // completion interrupt
   // ------------------------------------------------------------
   wire wr_status_clr = wr_fire && awaddr_q == `CRCX_OFS_IRQ_STATUS && wstrb_q[0]
                        && wdata_q[`CRCX_IRQ_DONE];

   always @(posedge aclk) begin
      if (!aresetn) begin
         busy_prev_q <= 1'b0;
         done_flag_q <= 1'b0;
      end else begin
         busy_prev_q <= busy;
         // a fall in the clearing cycle still sets the flag
         if (busy_prev_q && !busy) begin
            done_flag_q <= 1'b1;
         end else if (wr_status_clr) begin
            done_flag_q <= 1'b0;
         end
      end
   end

   assign irq = done_flag_q && done_mask_q;

endmodule // crcx_top

`default_nettype wire

/* logic/crcx_regs.vh */
// register map, field positions, reset values and sizes of the crc engine
// assumes inclusion by bare name from the crc design files
`ifndef CRCX_REGS_VH
`define CRCX_REGS_VH

// ------------------------------------------------------------
// byte addresses on the axi4-lite bus
// ------------------------------------------------------------
`define CRCX_ADDR_W 8
`define CRCX_OFS_CHECK_CONTROL_0 8'h00
`define CRCX_OFS_CHECK_CONTROL_1 8'h04
`define CRCX_OFS_CHECK_ACCUMULATOR 8'h08
`define CRCX_OFS_GENERATOR_POLY_REG 8'h0C
`define CRCX_OFS_INPUT_WORD_LOW 8'h10
`define CRCX_OFS_INPUT_WORD_HIGH 8'h14
`define CRCX_OFS_IRQ_STATUS 8'h18
`define CRCX_OFS_IRQ_MASK 8'h1C

// ------------------------------------------------------------
// check_control_0 fields
// ------------------------------------------------------------
`define CRCX_C0_CALC_GO 0
`define CRCX_C0_AUGMENT 1
`define CRCX_C0_BIT_ORDER 2
`define CRCX_C0_BUSY 4
`define CRCX_C0_FULL 5

// ------------------------------------------------------------
// check_control_1 fields
// ------------------------------------------------------------
`define CRCX_C1_WORD_LEN_LSB 0
`define CRCX_C1_POLY_LEN_LSB 4
`define CRCX_LEN_W 4

// ------------------------------------------------------------
// irq bits, reset values, bus answers
// ------------------------------------------------------------
`define CRCX_IRQ_DONE 0
`define CRCX_RST_CTRL0 3'h0
`define CRCX_RST_CTRL1 8'h00
`define CRCX_RST_WORD 16'h0000
`define CRCX_RESP_OKAY 2'h0
`define CRCX_RESP_SLVERR 2'h2

`endif

/* logic/crcx_step.v */
// one bit of crc polynomial division for a configurable width
// assumes the caller supplies a stable configuration; purely combinational
`timescale 1ns/10ps
`default_nettype none

module crcx_step #(
   parameter W = 16
) (
   // current state
   input wire [W-1:0] acc_in,
   input wire din,
   // configuration
   input wire [W-1:1] poly_hi,
   input wire [3:0] top_idx,
   // result
   output reg [W-1:0] acc_out
);

   reg [W-1:0] mask;
   reg fb;
   integer i;

   always @* begin
      mask = {W{1'b0}};
      for (i = 0; i < W; i = i + 1) begin
         if (i <= top_idx) begin
            mask[i] = 1'b1;
         end
      end
      // data enters at bit 0 and the bit leaving the top decides the feedback,
      // so only the trailing zeros of augmented mode yield the check value
      fb = acc_in[top_idx];
      acc_out = {acc_in[W-2:0], din} & mask;
      if (fb) begin
         // lowest coefficient always taken as one
         acc_out = acc_out ^ ({poly_hi, 1'b1} & mask);
      end
   end

endmodule // crcx_step

`default_nettype wire

/* testbench/crcx_top_chk.sv */
// checker: bus and scanner timing at the crcx_top ports
// assumes a bind onto crcx_top; one clock aclk, reset aresetn low
`timescale 1ns/10ps
`default_nettype none
`include "crcx_regs.vh"
module crcx_chk (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic [`CRCX_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read channels
   input wire logic [`CRCX_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // scanner
   input wire logic scan_valid,
   input wire logic scan_ready
);
   // --------------------------------
   // properties
   // --------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire ar = s_axi_arvalid && s_axi_arready;
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write response not held");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read data not held");
   property p_arrdy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arrdy: assert property (p_arrdy) else $error("read address taken while answer pending");
   property p_wok; aw_w && s_axi_awaddr < 8'h20 && s_axi_awaddr[1:0] == 2'h0 && s_axi_wstrb == 4'hF
      |-> ##2 s_axi_bvalid && s_axi_bresp == `CRCX_RESP_OKAY; endproperty
   a_wok: assert property (p_wok) else $error("mapped write not answered okay");
   property p_werr; aw_w && s_axi_awaddr >= 8'h20 |-> ##2 s_axi_bvalid && s_axi_bresp == `CRCX_RESP_SLVERR;
   endproperty
   a_werr: assert property (p_werr) else $error("unmapped write not refused");
   property p_rerr; ar && s_axi_araddr >= 8'h20
      |=> s_axi_rvalid && s_axi_rresp == `CRCX_RESP_SLVERR && s_axi_rdata == 32'h0000_0000; endproperty
   a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
   property p_rhi; ar |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000; endproperty
   a_rhi: assert property (p_rhi) else $error("upper read bits not zero");
   property p_poly0; ar && s_axi_araddr == `CRCX_OFS_GENERATOR_POLY_REG |=> s_axi_rdata[0] == 1'b0; endproperty
   a_poly0: assert property (p_poly0) else $error("polynomial bit 0 not zero");
   property p_scan; scan_valid && scan_ready |=> !scan_ready; endproperty
   a_scan: assert property (p_scan) else $error("scanner word taken while shifting");
endmodule // crcx_chk
bind crcx_top crcx_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .scan_valid(scan_valid), .scan_ready(scan_ready));
`default_nettype wire

/* testbench/crcx_scan_model.sv */
// scanner stand-in: offers one word per push on the scan port
// assumes push is pulsed only while idle; same clock as the engine
`timescale 1ns/10ps
`default_nettype none
module crcx_scan_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bench request
   input wire logic push,
   input wire logic [15:0] word_in,
   output logic taken,
   // scan port
   output logic [15:0] scan_data,
   output logic scan_valid,
   input wire logic scan_ready
);
   // --------------------------------
   // word offer
   // --------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         scan_valid <= 1'b0;
         scan_data <= 16'h0000;
         taken <= 1'b0;
      end else begin
         taken <= scan_valid && scan_ready;
         if (scan_valid && scan_ready) begin
            scan_valid <= 1'b0;
            // released lines flip so a late sample cannot pass
            scan_data <= ~scan_data;
         end else if (push && !scan_valid) begin
            scan_valid <= 1'b1;
            scan_data <= word_in;
         end
      end
   end
endmodule // crcx_scan_model
`default_nettype wire

/* testbench/crcx_top_tb.sv */
// testbench: registers, crc results, interrupt and scanner feed
// assumes crcx_top, the scanner model and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "crcx_regs.vh"
module crcx_top_tb;
   // --------------------------------
   // signals
   // --------------------------------
   localparam [7:0] C0 = `CRCX_OFS_CHECK_CONTROL_0;
   localparam [7:0] C1 = `CRCX_OFS_CHECK_CONTROL_1;
   localparam [7:0] ACC = `CRCX_OFS_CHECK_ACCUMULATOR;
   localparam [7:0] POLY = `CRCX_OFS_GENERATOR_POLY_REG;
   localparam [7:0] STAT = `CRCX_OFS_IRQ_STATUS;
   localparam [7:0] MASK = `CRCX_OFS_IRQ_MASK;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic push = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [15:0] word = 16'h0000;
   wire awready, wready, bvalid, arready, rvalid, scan_valid, scan_ready, irq, taken;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] scan_data;
   logic [31:0] d;
   logic [1:0] r;
   logic [15:0] e;
   logic [7:0] exd [4] = '{8'h55, 8'h66, 8'h77, 8'h88};
   logic [15:0] sw [2] = '{16'hC3A9, 16'h1F00};
   integer errors = 0;
   integer tests_run = 0;
   integer i, j;
   always #25 aclk = ~aclk;
   crcx_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scan_data(scan_data),
      .scan_valid(scan_valid), .scan_ready(scan_ready), .irq(irq));
   crcx_scan_model u_scan (.aclk(aclk), .aresetn(aresetn), .push(push), .word_in(word), .taken(taken),
      .scan_data(scan_data), .scan_valid(scan_valid), .scan_ready(scan_ready));
   // --------------------------------
   // tasks
   // --------------------------------
   task automatic chk(input [31:0] seen, input [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input [7:0] a, input [31:0] v);
      logic done;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~v;
         end
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rd(input [7:0] a);
      logic done;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   // waits until a control_0 status bit reads clear
   task automatic poll(input integer b);
      d = 32'hFFFF_FFFF;
      while (d[b]) rd(C0);
   endtask
   function automatic [15:0] crc_ref(input [15:0] acc, input [15:0] wd, input integer n, input integer pl,
      input [15:0] poly, input lsb);
      integer k;
      logic fb;
      logic [15:0] m;
      m = 16'hFFFF >> (15 - pl);
      for (k = 0; k < n; k++) begin
         fb = acc[pl];
         acc = ((acc << 1) | (lsb ? wd[k] : wd[n-1-k])) & m;
         if (fb) acc = acc ^ ({poly[15:1], 1'b1} & m);
      end
      crc_ref = acc;
   endfunction
   task automatic complete_run;
      if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // --------------------------------
   // scenarios
   // --------------------------------
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 8; i++) begin
         rd(8'(i * 4));
         chk(d, 32'h0000_0000);
      end
      rd(8'h20);
      chk(r, `CRCX_RESP_SLVERR);
      wr(8'h24, 32'h0000_0001);
      chk(r, `CRCX_RESP_SLVERR);
      wr(POLY, 32'h0000_FFFF);
      rd(POLY);
      chk(d, 32'h0000_FFFE);
      // both bit orders of the 16-bit augmented example
      for (i = 0; i < 2; i++) begin
         wr(C1, 32'h0000_00F7);
         wr(POLY, 32'h0000_8005);
         wr(ACC, 32'h0000_0000);
         wr(MASK, 32'h0000_0001);
         wr(C0, 32'(i * 4 + 3));
         for (j = 0; j < 4; j++) begin
            poll(`CRCX_C0_FULL);
            wr(`CRCX_OFS_INPUT_WORD_LOW, 32'(exd[j]));
         end
         poll(`CRCX_C0_FULL);
         wr(C0, 32'(i * 4 + 2));
         poll(`CRCX_C0_BUSY);
         rd(ACC);
         chk(d, i ? 32'h0000_6BA2 : 32'h0000_32D6);
         chk(irq, 1'b1);
         wr(STAT, 32'h0000_0001);
         chk(irq, 1'b0);
      end
      // 12-bit word, seeded, high byte first, interrupt masked
      wr(MASK, 32'h0000_0000);
      wr(C1, 32'h0000_00FB);
      wr(ACC, 32'h0000_FFFF);
      wr(C0, 32'h0000_0001);
      wr(`CRCX_OFS_INPUT_WORD_HIGH, 32'h0000_00FA);
      wr(`CRCX_OFS_INPUT_WORD_LOW, 32'h0000_005C);
      poll(`CRCX_C0_BUSY);
      rd(ACC);
      chk(d, 32'(crc_ref(16'hFFFF, 16'hFA5C, 12, 15, 16'h8005, 1'b0)));
      rd(STAT);
      chk(d, 32'h0000_0001);
      chk(irq, 1'b0);
      wr(STAT, 32'h0000_0001);
      // 8-bit crc over two scanner words, lsb first
      wr(C1, 32'h0000_007F);
      wr(POLY, 32'h0000_0007);
      wr(ACC, 32'h0000_00A5);
      wr(MASK, 32'h0000_0001);
      wr(C0, 32'h0000_0005);
      e = 16'h00A5;
      for (j = 0; j < 2; j++) begin
         word <= sw[j];
         push <= 1'b1;
         @(posedge aclk);
         push <= 1'b0;
         while (!taken) @(posedge aclk);
         e = crc_ref(e, sw[j], 16, 7, 16'h0007, 1'b1);
      end
      poll(`CRCX_C0_BUSY);
      rd(ACC);
      chk(d, 32'(e));
      chk(irq, 1'b1);
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      errors = errors + 1;
      complete_run;
   end
endmodule // crcx_top_tb
`default_nettype wire
